//--- rtl/drm_pkg.sv
// Package for the debug register/memory read command block.
// Assumes every user of it names items as drm_pkg::name, with no import.
package drm_pkg;

    // ------------------------------------------------------------
    // command bytes
    // ------------------------------------------------------------
    // core register read is this upper nibble plus the register number
    localparam logic [3:0] CORE_CMD_HI   = 4'h6;
    localparam logic [7:0] CMD_MEM_BYTE  = 8'h30;
    localparam logic [7:0] CMD_MEM_HALF  = 8'h34;
    localparam logic [7:0] CMD_MEM_WORD  = 8'h38;

    // ------------------------------------------------------------
    // field layout and counts
    // ------------------------------------------------------------
    localparam int         CRN_W         = 4;
    localparam int         ADDR_W        = 24;
    localparam int         DATA_W        = 32;
    localparam logic [1:0] ADDR_LAST_IDX = 2'h2;
    localparam logic [2:0] BYTES_ONE     = 3'h1;
    localparam logic [2:0] BYTES_TWO     = 3'h2;
    localparam logic [2:0] BYTES_FOUR    = 3'h4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [23:0] ADDR_RST     = 24'h00_0000;
    localparam logic [31:0] DATA_RST     = 32'h0000_0000;
    localparam logic [3:0]  CRN_RST      = 4'h0;

    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_HALF,
        SZ_WORD
    } drm_size_e;

endpackage : drm_pkg

//--- rtl/drm_tx_if.sv
// Carrier between the command controller and its byte sender.
// Assumes both ends share one clock; load is a one-cycle strobe.
`timescale 1ns/100ps
interface drm_tx_if;
    logic        load;
    logic [31:0] word;
    logic [2:0]  nbytes;
    logic        busy;

    modport ctrl (output load, output word, output nbytes, input busy);
    modport send (input load, input word, input nbytes, output busy);
endinterface : drm_tx_if

//--- rtl/drm_byte_tx.sv
// Byte sender: returns one, two or four bytes of a word, most significant first.
// Assumes load only arrives while busy is low and the sink holds ready per byte.
`timescale 1ns/100ps
module drm_byte_tx (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // controller side
    drm_tx_if.send          tx,
    // byte stream to the link layer
    output logic [7:0]      tx_data_o,
    output logic            tx_valid_o,
    input  wire logic       tx_ready_i
);

    logic [31:0] shift_q;
    logic [31:0] shift_d;
    logic [2:0]  count_q;
    logic [2:0]  count_d;
    logic [31:0] aligned;
    logic        take;

    // ------------------------------------------------------------
    // alignment: first byte always sits in the top lane
    // ------------------------------------------------------------
    assign aligned = (tx.nbytes == drm_pkg::BYTES_ONE) ? {tx.word[7:0], 24'h00_0000} :
                     (tx.nbytes == drm_pkg::BYTES_TWO) ? {tx.word[15:0], 16'h0000} :
                     tx.word;
    assign take    = tx_valid_o && tx_ready_i;
    assign shift_d = tx.load ? aligned : (take ? {shift_q[23:0], 8'h00} : shift_q);
    assign count_d = tx.load ? tx.nbytes : (take ? count_q - 3'h1 : count_q);

    assign tx_valid_o = (count_q != 3'h0);
    assign tx_data_o  = shift_q[31:24];
    assign tx.busy    = tx_valid_o;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q <= drm_pkg::DATA_RST;
            count_q <= 3'h0;
        end else begin
            shift_q <= shift_d;
            count_q <= count_d;
        end
    end

endmodule : drm_byte_tx

//--- rtl/drm_read_ctrl.sv
// Command controller for core register and memory reads on the debug link.
// Assumes a byte-level link layer on SYS_CLK_I; halt and ack enable are local levels.
// Notes on behaviour
// - core read: 0x60 plus number, four bytes
// - core reads always move 32 bits
// - unimplemented core bytes read as zero
// - acknowledge pulse precedes data when enabled
// - core read outside halt: flag, no access
// - memory read: size command, 24-bit address
`timescale 1ns/100ps
module drm_read_ctrl (
    // clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        SYS_RST_I,
    // command bytes from host
    input  wire logic [7:0]  RX_DATA_I,
    input  wire logic        RX_VALID_I,
    output logic             RX_READY_O,
    // data bytes to host
    output logic [7:0]       TX_DATA_O,
    output logic             TX_VALID_O,
    input  wire logic        TX_READY_I,
    // acknowledge
    input  wire logic        ACK_EN_I,
    output logic             ACK_PULSE_O,
    // debug state
    input  wire logic        HALTED_I,
    output logic             ILLEGAL_CMD_O,
    input  wire logic        ILLEGAL_CLR_I,
    // core register port
    output logic             CREG_REQ_O,
    output logic [3:0]       CREG_NUM_O,
    input  wire logic        CREG_ACK_I,
    input  wire logic [31:0] CREG_DATA_I,
    input  wire logic [2:0]  CREG_BYTES_I,
    // memory port
    output logic             MEM_REQ_O,
    output logic [23:0]      MEM_ADDR_O,
    output logic [1:0]       MEM_SIZE_O,
    input  wire logic        MEM_ACK_I,
    input  wire logic [31:0] MEM_DATA_I
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CORE,
        ST_MEM,
        ST_ACK,
        ST_LOAD,
        ST_SEND
    } drm_state_e;

    drm_state_e          state_q;
    drm_state_e          state_d;
    logic [3:0]          crn_q;
    logic [23:0]         addr_q;
    logic [1:0]          addr_cnt_q;
    drm_pkg::drm_size_e  size_q;
    logic [31:0]         data_q;
    logic [2:0]          nbytes_q;
    logic                illegal_q;

    drm_tx_if tx ();

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic                rx_take;
    logic                is_core;
    logic                is_mem;
    logic                core_ok;
    logic                core_bad;
    logic                creg_done;
    logic                mem_done;
    logic                addr_done;
    drm_pkg::drm_size_e  cmd_size;
    logic [31:0]         creg_masked;
    logic [31:0]         mem_masked;
    logic [2:0]          mem_bytes;
    logic [7:0]          first_byte;

    assign rx_take   = RX_VALID_I && RX_READY_O;
    assign is_core   = (RX_DATA_I[7:4] == drm_pkg::CORE_CMD_HI);
    assign is_mem    = (RX_DATA_I == drm_pkg::CMD_MEM_BYTE) ||
                       (RX_DATA_I == drm_pkg::CMD_MEM_HALF) ||
                       (RX_DATA_I == drm_pkg::CMD_MEM_WORD);
    assign cmd_size  = (RX_DATA_I == drm_pkg::CMD_MEM_BYTE) ? drm_pkg::SZ_BYTE :
                       (RX_DATA_I == drm_pkg::CMD_MEM_HALF) ? drm_pkg::SZ_HALF :
                       drm_pkg::SZ_WORD;
    assign core_ok   = (state_q == ST_IDLE) && rx_take && is_core && HALTED_I;
    assign core_bad  = (state_q == ST_IDLE) && rx_take && is_core && !HALTED_I;
    assign addr_done = (state_q == ST_ADDR) && rx_take && (addr_cnt_q == drm_pkg::ADDR_LAST_IDX);
    assign creg_done = (state_q == ST_CORE) && CREG_ACK_I;
    assign mem_done  = (state_q == ST_MEM) && MEM_ACK_I;

    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign creg_masked[b*8 +: 8] = (3'(b) < CREG_BYTES_I) ? CREG_DATA_I[b*8 +: 8] : 8'h00;
    end

    assign mem_bytes  = (size_q == drm_pkg::SZ_BYTE) ? drm_pkg::BYTES_ONE :
                        (size_q == drm_pkg::SZ_HALF) ? drm_pkg::BYTES_TWO :
                        drm_pkg::BYTES_FOUR;
    assign mem_masked = (size_q == drm_pkg::SZ_BYTE) ? {24'h00_0000, MEM_DATA_I[7:0]} :
                        (size_q == drm_pkg::SZ_HALF) ? {16'h0000, MEM_DATA_I[15:0]} :
                        MEM_DATA_I;
    assign first_byte = (nbytes_q == drm_pkg::BYTES_ONE) ? data_q[7:0] :
                        (nbytes_q == drm_pkg::BYTES_TWO) ? data_q[15:8] : data_q[31:24];

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // commands arriving during a transfer are not taken
    assign RX_READY_O    = (state_q == ST_IDLE) || (state_q == ST_ADDR);
    assign CREG_REQ_O    = (state_q == ST_CORE);
    assign CREG_NUM_O    = crn_q;
    assign MEM_REQ_O     = (state_q == ST_MEM);
    assign MEM_ADDR_O    = addr_q;
    assign MEM_SIZE_O    = size_q;
    // pulse sits between access and data
    assign ACK_PULSE_O   = (state_q == ST_ACK);
    assign ILLEGAL_CMD_O = illegal_q;
    assign tx.load       = (state_q == ST_LOAD);
    assign tx.word       = data_q;
    assign tx.nbytes     = nbytes_q;

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (core_ok) begin
                    state_d = ST_CORE;
                end else if (rx_take && is_mem) begin
                    state_d = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (addr_done) begin
                    state_d = ST_MEM;
                end
            end
            ST_CORE: begin
                if (CREG_ACK_I) begin
                    state_d = ACK_EN_I ? ST_ACK : ST_LOAD;
                end
            end
            ST_MEM: begin
                if (MEM_ACK_I) begin
                    state_d = ACK_EN_I ? ST_ACK : ST_LOAD;
                end
            end
            ST_ACK:  state_d = ST_LOAD;
            ST_LOAD: state_d = ST_SEND;
            ST_SEND: begin
                if (!tx.busy) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            crn_q <= drm_pkg::CRN_RST;
        end else if (core_ok) begin
            crn_q <= RX_DATA_I[3:0];
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            addr_q     <= drm_pkg::ADDR_RST;
            addr_cnt_q <= 2'h0;
            size_q     <= drm_pkg::SZ_BYTE;
        end else if ((state_q == ST_IDLE) && rx_take && is_mem) begin
            addr_cnt_q <= 2'h0;
            size_q     <= cmd_size;
        end else if ((state_q == ST_ADDR) && rx_take) begin
            addr_q     <= {addr_q[15:0], RX_DATA_I};
            addr_cnt_q <= addr_cnt_q + 2'h1;
        end
    end

    // core result is always four bytes
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            data_q   <= drm_pkg::DATA_RST;
            nbytes_q <= drm_pkg::BYTES_FOUR;
        end else if (creg_done) begin
            data_q   <= creg_masked;
            nbytes_q <= drm_pkg::BYTES_FOUR;
        end else if (mem_done) begin
            data_q   <= mem_masked;
            nbytes_q <= mem_bytes;
        end
    end

    // sticky flag, a new event beats the clear
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            illegal_q <= 1'b0;
        end else if (core_bad) begin
            illegal_q <= 1'b1;
        end else if (ILLEGAL_CLR_I) begin
            illegal_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // byte sender
    // ------------------------------------------------------------
    drm_byte_tx u_byte_tx (
        .clk_i      (SYS_CLK_I),
        .rst_i      (SYS_RST_I),
        .tx         (tx.send),
        .tx_data_o  (TX_DATA_O),
        .tx_valid_o (TX_VALID_O),
        .tx_ready_i (TX_READY_I)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    crn_forward_a: assert property (
        core_ok |=> CREG_REQ_O && (CREG_NUM_O == $past(RX_DATA_I[3:0])))
        else $error("core register number not forwarded");

    msb_first_a: assert property (
        (state_q == ST_LOAD) |=> TX_VALID_O && (TX_DATA_O == $past(first_byte)))
        else $error("first data byte is not the most significant");

    core_width_a: assert property (
        creg_done |=> (nbytes_q == drm_pkg::BYTES_FOUR))
        else $error("core read not four bytes");

    core_zero_a: assert property (
        creg_done && (CREG_BYTES_I == drm_pkg::BYTES_ONE) |=> (data_q[31:8] == 24'h00_0000))
        else $error("unimplemented core bytes not zero");

    ack_order_a: assert property (
        (creg_done || mem_done) && ACK_EN_I
        |=> ACK_PULSE_O && !TX_VALID_O ##1 !ACK_PULSE_O && !TX_VALID_O ##1 TX_VALID_O)
        else $error("acknowledge pulse not ahead of data");

    illegal_core_a: assert property (
        core_bad |=> ILLEGAL_CMD_O && !CREG_REQ_O && (state_q == ST_IDLE))
        else $error("core read outside halt not rejected");

    addr_assembly_a: assert property (
        addr_done |=> MEM_REQ_O && (MEM_ADDR_O[7:0] == $past(RX_DATA_I)))
        else $error("address low byte not last");

    mem_half_a: assert property (
        mem_done && (size_q == drm_pkg::SZ_HALF) |=> (nbytes_q == drm_pkg::BYTES_TWO))
        else $error("16-bit read not two bytes");

endmodule : drm_read_ctrl

//--- tb/drm_host_model.sv
// Host model: offers command and address bytes, takes the returned data bytes.
// Assumes one bench process calls its tasks; all timing is on clk_i.
`timescale 1ns/100ps
module drm_host_model (
    // clock
    input  wire logic       clk_i,
    // command byte stream
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i,
    // data byte stream
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    // stall control
    input  wire logic       slow_i
);
    initial begin
        rx_data_o  = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b1;
    end

    // slow mode halves the sink rate so each byte must stand
    always @(posedge clk_i) begin
        #1;
        tx_ready_o = slow_i ? ~tx_ready_o : 1'b1;
    end

    task automatic send_byte(input logic [7:0] b, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge clk_i);
        #1;
        rx_data_o  = b;
        rx_valid_o = 1'b1;
        for (n = 0; n < 50 && !ok; n++) begin
            @(negedge clk_i);
            ok = (rx_ready_i === 1'b1);
        end
        @(posedge clk_i);
        #1;
        // released line shows the inverse, never the stale byte
        rx_valid_o = 1'b0;
        rx_data_o  = ~b;
    endtask : send_byte

    task automatic get_byte(output logic [7:0] b, output logic ok);
        int n;
        ok = 1'b0;
        b  = 8'h00;
        for (n = 0; n < 50 && !ok; n++) begin
            @(negedge clk_i);
            ok = (tx_valid_i === 1'b1 && tx_ready_o === 1'b1);
            b  = tx_data_i;
        end
        @(posedge clk_i);
    endtask : get_byte
endmodule : drm_host_model

//--- tb/debug_register_memory_read_bench.sv
// Bench for the read command controller: host model plus core and memory responders.
// Assumes the design package is compiled first; no registers, one clock.
`timescale 1ns/100ps
module debug_register_memory_read_bench;
    logic        clk = 1'b0;
    logic        rst, halted, ack_en, clr, creg_ack, mem_ack, slow;
    logic [31:0] creg_data, mem_data;
    logic [2:0]  creg_bytes;
    logic [7:0]  rx_data, tx_data;
    logic        rx_valid, rx_ready, tx_valid, tx_ready;
    logic        ack_pulse, illegal, creg_req, mem_req;
    logic [3:0]  creg_num, num_seen;
    logic [23:0] mem_addr, addr_seen;
    logic [1:0]  mem_size, size_seen;
    int          err_count, check_count, cycles, ack_cnt, creg_cnt;

    drm_read_ctrl u_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .RX_DATA_I(rx_data),
        .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready), .TX_DATA_O(tx_data),
        .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready), .ACK_EN_I(ack_en),
        .ACK_PULSE_O(ack_pulse), .HALTED_I(halted), .ILLEGAL_CMD_O(illegal),
        .ILLEGAL_CLR_I(clr), .CREG_REQ_O(creg_req), .CREG_NUM_O(creg_num),
        .CREG_ACK_I(creg_ack), .CREG_DATA_I(creg_data), .CREG_BYTES_I(creg_bytes),
        .MEM_REQ_O(mem_req), .MEM_ADDR_O(mem_addr), .MEM_SIZE_O(mem_size),
        .MEM_ACK_I(mem_ack), .MEM_DATA_I(mem_data));

    drm_host_model u_host (.clk_i(clk), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .slow_i(slow));

    always #5 clk = ~clk;

    // -------------------------------------------------------------
    // responders, monitor and timeout
    // -------------------------------------------------------------
    always @(posedge clk) begin
        #1;
        creg_ack = (creg_req === 1'b1) && !creg_ack;
        mem_ack  = (mem_req === 1'b1) && !mem_ack;
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    always @(negedge clk) begin
        if (ack_pulse === 1'b1)
            ack_cnt++;
        if (creg_req === 1'b1) begin
            creg_cnt++;
            num_seen = creg_num;
        end
        if (mem_req === 1'b1) begin
            addr_seen = mem_addr;
            size_seen = mem_size;
        end
    end

    // -------------------------------------------------------------
    // compare and closing tasks
    // -------------------------------------------------------------
    task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_vec

    task automatic chk_bit(input logic got, input logic exp, input string m);
        chk_vec({31'h0, got}, {31'h0, exp}, m);
    endtask : chk_bit

    task automatic give_verdict();
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic get_data(input int n, input logic [31:0] exp, input logic en);
        logic [7:0] b;
        logic       ok;
        int         i;
        for (i = n - 1; i >= 0; i--) begin
            u_host.get_byte(b, ok);
            chk_bit(ok, 1'b1, "data byte missing");
            chk_vec({24'h0, b}, {24'h0, exp[8*i +: 8]}, "data byte");
            if (i == n - 1)
                chk_vec(32'(ack_cnt), {31'h0, en}, "ack before data");
        end
        @(negedge clk);
        chk_bit(tx_valid, 1'b0, "extra data byte");
    endtask : get_data

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic core_read(input logic [3:0] num, input logic [2:0] nb, input logic en);
        logic ok;
        @(posedge clk);
        #1;
        halted     = 1'b1;
        ack_en     = en;
        creg_bytes = nb;
        creg_data  = 32'hc3a5_5a3c ^ {28'h0, num};
        ack_cnt    = 0;
        creg_cnt   = 0;
        u_host.send_byte({drm_pkg::CORE_CMD_HI, num}, ok);
        chk_bit(ok, 1'b1, "command refused");
        // unimplemented upper lanes read zero
        get_data(4, creg_data & ~(32'hffff_ffff << (8 * nb)), en);
        chk_vec({28'h0, num_seen}, {28'h0, num}, "register number");
        chk_vec(32'(creg_cnt), 32'h1, "one register access");
    endtask : core_read

    task automatic illegal_read();
        logic ok;
        @(posedge clk);
        #1;
        halted   = 1'b0;
        creg_cnt = 0;
        u_host.send_byte(8'h6b, ok);
        repeat (2) @(negedge clk);
        chk_bit(illegal, 1'b1, "flag not set");
        chk_vec(32'(creg_cnt), 32'h0, "access made");
        chk_bit(rx_ready, 1'b1, "not idle");
        @(posedge clk);
        #1;
        clr = 1'b1;
        @(posedge clk);
        #1;
        clr = 1'b0;
        @(negedge clk);
        chk_bit(illegal, 1'b0, "flag not cleared");
        // clear held through the take edge: a new illegal command must win
        @(posedge clk);
        #1;
        clr = 1'b1;
        u_host.send_byte(8'h6b, ok);
        clr = 1'b0;
        @(negedge clk);
        chk_bit(illegal, 1'b1, "clear beat the set");
    endtask : illegal_read

    task automatic mem_read(input logic [7:0] cmd, input int n, input logic [1:0] sz,
                            input logic [23:0] addr, input logic stall, input logic en);
        logic ok;
        int   i;
        @(posedge clk);
        #1;
        ack_en   = en;
        slow     = stall;
        mem_data = 32'h9e37_b16d;
        ack_cnt  = 0;
        u_host.send_byte(cmd, ok);
        chk_bit(ok, 1'b1, "command refused");
        for (i = 2; i >= 0; i--) begin
            u_host.send_byte(addr[8*i +: 8], ok);
            chk_bit(ok, 1'b1, "address refused");
        end
        get_data(n, mem_data & ~(32'hffff_ffff << (8 * n)), en);
        chk_vec({8'h0, addr_seen}, {8'h0, addr}, "address");
        chk_vec({30'h0, size_seen}, {30'h0, sz}, "size");
    endtask : mem_read

    initial begin
        int i;
        rst        = 1'b1;
        halted     = 1'b0;
        ack_en     = 1'b0;
        clr        = 1'b0;
        creg_ack   = 1'b0;
        mem_ack    = 1'b0;
        slow       = 1'b0;
        creg_data  = 32'h0;
        mem_data   = 32'h0;
        creg_bytes = 3'h4;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        @(negedge clk);
        chk_bit(rx_ready, 1'b1, "reset ready");
        chk_bit(tx_valid | creg_req | mem_req | illegal, 1'b0, "reset outputs");
        for (i = 1; i <= 4; i++)
            core_read(4'(3 * i), 3'(i), i[0]);
        core_read(4'hf, 3'h4, 1'b1);
        illegal_read();
        mem_read(drm_pkg::CMD_MEM_BYTE, 1, drm_pkg::SZ_BYTE, 24'h12_3456, 1'b0, 1'b1);
        mem_read(drm_pkg::CMD_MEM_HALF, 2, drm_pkg::SZ_HALF, 24'hfe_dc01, 1'b1, 1'b0);
        mem_read(drm_pkg::CMD_MEM_WORD, 4, drm_pkg::SZ_WORD, 24'h80_00ff, 1'b1, 1'b1);
        give_verdict();
    end
endmodule : debug_register_memory_read_bench
